// ### common/scs_pkg.sv
// constants, encodings and state type for the system clock source select block
// assumes a single 125 MHz ref_clk domain; oscillator pins arrive asynchronously
// Summary of operation
// - decode 4-bit source: external, RC 8 MHz, watchdog 128 kHz, low-freq, crystal
// - fuse bit reads one unprogrammed, zero programmed; encodings use that polarity
// - wake or source switch counts selected-source start-up cycles before execution
// - after reset add watchdog-timed delay: none, 512 or 8192 watchdog cycles
// - reset copies fuses into clock select register; block then uses its fields
// - factory default: RC source, start-up code 10, divide-by-eight active
// - reset loads factory trim value into oscillator trim register
// - software may rewrite oscillator trim; written value drives the oscillator
// - watchdog and reset time-out stay on watchdog oscillator whatever the source
// - RC source: wake 6 clocks; reset adds 14, 14+4.1 ms, 14+65 ms; 11 reserved
// - start-up code 00 for internal oscillators only without reset-pin-disable fuse
// - watchdog source: wake 6 clocks; reset adds 14 plus optional 4.1 or 65 ms
// - crystal amplifier range from select bits 3..1: 100,101,110,111
// - crystal start-up from bit 0 and code: 258, 1024 or 16384 clocks
package scs_pkg;
  localparam logic [3:0] SRC_EXT = 4'h0;
  localparam logic [3:0] SRC_BAD = 4'h1;
  localparam logic [3:0] SRC_RC = 4'h2;
  localparam logic [3:0] SRC_WDO = 4'h3;
  localparam logic [1:0] SUT_BAD = 2'h3;
  localparam logic [3:0] DEF_SRC = 4'h2;
  localparam logic [1:0] DEF_SUT = 2'h2;
  localparam logic [7:0] DEF_TRIM = 8'h80;
  localparam logic [7:0] ADDR_CLKSEL = 8'h00;
  localparam logic [7:0] ADDR_TRIM = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CS_SRC_LSB = 0;
  localparam int CS_SUT_LSB = 4;
  localparam logic [16:0] WAKE_SHORT = 17'h00006;
  localparam logic [16:0] RST_EXTRA_CK = 17'h0000e;
  localparam logic [16:0] XT_SHORT = 17'h00102;
  localparam logic [16:0] XT_MID = 17'h00400;
  localparam logic [1:0] DLY_NONE = 2'h0;
  localparam logic [1:0] DLY_SHORT = 2'h1;
  localparam logic [1:0] DLY_LONG = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_LOAD = 4'h1,
    ST_WD = 4'h2,
    ST_CNT = 4'h4,
    ST_RUN = 4'h8
  } scs_state_t;
endpackage

// ### testbench/scs_osc_model.sv
// oscillator stand-ins: watchdog oscillator and the selected clock source
// assumes a ns timescale; half-periods stay well above three ref_clk cycles
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model #(
  parameter int WD_HALF_NS = 60,
  parameter int SRC_HALF_NS = 44
) (
  output logic wd_osc_pin,
  output logic src_osc_pin
);
  // free-running on its own, unrelated in phase to ref_clk
  initial begin
    wd_osc_pin = 1'b0;
    forever #(WD_HALF_NS) wd_osc_pin = ~wd_osc_pin;
  end
  // acts as a ceramic resonator, so the lowest amplifier range is a fair pick
  initial begin
    src_osc_pin = 1'b0;
    #17;
    forever #(SRC_HALF_NS) src_osc_pin = ~src_osc_pin;
  end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the clock source select block
// assumes scs_pkg and the design are compiled first; oscillators come from scs_osc_model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
    int wlen;
  } scs_row_t;
  localparam int WDL = 16;
  localparam int XTL = 32;
  localparam int LFL = 64;
  logic ref_clk, rst, ce, wake_req, div8_fuse, rpd_fuse;
  logic [3:0] cs_fuse;
  logic [1:0] sut_fuse;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, sut_f, xr;
  logic [3:0] src_f, wstrb;
  logic [7:0] trim, ftrim;
  logic amp, div8, cpu_run, busy, wdon, wd_pin, src_pin;
  int err_total = 0;
  int total_checks = 0;
  int wd_cnt = 0;
  int src_cnt = 0;
  // fuses read one when unprogrammed: factory trim 0x5a, div8 fuse programmed
  scs_row_t rows [19] = '{
    '{1'b0, 8'h00, 32'h22, 2'h0, 0}, '{1'b0, 8'h04, 32'h5a, 2'h0, 0},
    '{1'b1, 8'h04, 32'h3c, 2'h0, 0}, '{1'b0, 8'h04, 32'h3c, 2'h0, 0},
    '{1'b1, 8'h00, 32'h01, 2'h2, 0}, '{1'b1, 8'h00, 32'h32, 2'h2, 0},
    '{1'b1, 8'h0c, 32'h11, 2'h2, 0}, '{1'b0, 8'h0c, 32'h00, 2'h2, 0},
    '{1'b1, 8'h08, 32'hff, 2'h2, 0}, '{1'b1, 8'h00, 32'h03, 2'h0, 6},
    '{1'b1, 8'h00, 32'h00, 2'h0, 6}, '{1'b1, 8'h00, 32'h18, 2'h0, 258},
    '{1'b1, 8'h00, 32'h2a, 2'h0, 1024}, '{1'b1, 8'h00, 32'h1c, 2'h0, 258},
    '{1'b1, 8'h00, 32'h1f, 2'h0, XTL}, '{1'b1, 8'h00, 32'h24, 2'h0, LFL},
    '{1'b1, 8'h00, 32'h12, 2'h0, 6}, '{1'b0, 8'h00, 32'h12, 2'h0, 0},
    '{1'b0, 8'h08, 32'ha5, 2'h0, 0}};
  scs_osc_model osc (.wd_osc_pin(wd_pin), .src_osc_pin(src_pin));
  scs_clock_select #(
    .WD_SHORT_CYC(17'h00008), .WD_LONG_CYC(17'h00010),
    .XT_LONG_CYC(17'h00020), .LF_LONG_CYC(17'h00040)
  ) uut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .clock_source_fuses(cs_fuse), .startup_time_fuses(sut_fuse),
    .divide_by_eight_fuse(div8_fuse), .reset_pin_disable_fuse(rpd_fuse),
    .factory_trim(ftrim), .wake_req(wake_req), .wd_osc_pin(wd_pin), .src_osc_pin(src_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .source_select_field(src_f), .startup_time_field(sut_f), .xtal_range(xr),
    .osc_amp_enable(amp), .div8_enable(div8), .osc_trim_register(trim),
    .cpu_run(cpu_run), .startup_busy(busy), .watchdog_on_wdosc(wdon)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge wd_pin) if (busy === 1'b1) wd_cnt++;
  always @(posedge src_pin) if (busy === 1'b1) src_cnt++;
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // counted edges may lead or lag the design's synchronised view by one
  task automatic wait_run(input int n);
    repeat (2) @(posedge ref_clk);
    while (cpu_run !== 1'b1) @(posedge ref_clk);
    chk(32'(src_cnt + 1 >= n && src_cnt <= n + 1), 32'h1);
  endtask
  task automatic do_reset(input logic [3:0] cs, input logic [1:0] su, input logic dv,
                          input logic rp);
    @(posedge ref_clk);
    rst <= 1'b1;
    cs_fuse <= cs;
    sut_fuse <= su;
    div8_fuse <= dv;
    rpd_fuse <= rp;
    repeat (5) @(posedge ref_clk);
    chk(32'({cpu_run, busy, src_f, div8, trim, wdon}), 32'h4b01);
    wd_cnt = 0;
    rst <= 1'b0;
    while (cpu_run !== 1'b1) @(posedge ref_clk);
    chk(32'(wd_cnt >= WDL), 32'h1);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rst = 1'b1;
    wake_req = 1'b0;
    cs_fuse = 4'h2;
    sut_fuse = 2'h2;
    div8_fuse = 1'b0;
    rpd_fuse = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    ce = 1'b1;
    wstrb = 4'hf;
    ftrim = 8'h5a;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    do_reset(4'h2, 2'h2, 1'b0, 1'b1);
    chk(32'({src_f, sut_f, div8, trim}), 32'h155a);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        src_cnt = 0;
        axi_wr(rows[i].addr, rows[i].data, r);
        chk(32'(r), 32'(rows[i].resp));
        if (rows[i].addr == 8'h04) chk(32'(trim), rows[i].data);
        if (rows[i].wlen > 0) begin
          wait_run(rows[i].wlen);
          d = rows[i].data;
          chk(32'({src_f, sut_f, xr, amp}),
              32'({d[3:0], d[5:4], d[2:1], d[3] | (d[3:2] == 2'b01)}));
        end
      end else begin
        axi_rd(rows[i].addr, d, r);
        chk(d, rows[i].data);
        chk(32'(r), 32'(rows[i].resp));
      end
    end
    @(posedge ref_clk);
    src_cnt = 0;
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    wait_run(6);
    // reset in mid-run with reset-pin-disable set: code 00 must fall back
    ftrim <= 8'ha5;
    do_reset(4'h2, 2'h0, 1'b1, 1'b0);
    chk(32'({sut_f, div8, trim}), 32'h4a5);
    axi_wr(8'h00, 32'h02, r);
    chk(32'(r), 32'(scs_pkg::RESP_SLVERR));
    chk(32'({wdon, src_f}), 32'h12);
    // byte lane 0 off: write answers okay and leaves the selection alone
    wstrb <= 4'h0;
    axi_wr(8'h00, 32'h03, r);
    chk(32'({r, src_f}), 32'h02);
    // a wake request while the clock enable is low must be ignored
    ce <= 1'b0;
    wake_req <= 1'b1;
    @(posedge ref_clk);
    wake_req <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(32'({cpu_run, busy}), 32'h2);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/scs_clock_select.sv
// system clock source select: fuse copy, clock select and trim registers, start-up timing
// assumes an axi4-lite master on ref_clk; oscillator pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module scs_clock_select #(
  parameter logic [16:0] WD_SHORT_CYC = 17'h00200,
  parameter logic [16:0] WD_LONG_CYC = 17'h02000,
  parameter logic [16:0] XT_LONG_CYC = 17'h04000,
  parameter logic [16:0] LF_LONG_CYC = 17'h08000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] clock_source_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic divide_by_eight_fuse,
  input wire logic reset_pin_disable_fuse,
  input wire logic [7:0] factory_trim,
  input wire logic wake_req,
  input wire logic wd_osc_pin,
  input wire logic src_osc_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] source_select_field,
  output logic [1:0] startup_time_field,
  output logic [1:0] xtal_range,
  output logic osc_amp_enable,
  output logic div8_enable,
  output logic [7:0] osc_trim_register,
  output logic cpu_run,
  output logic startup_busy,
  output logic watchdog_on_wdosc
);
  localparam scs_pkg::scs_state_t ST_LOAD = scs_pkg::ST_LOAD;
  localparam scs_pkg::scs_state_t ST_WD = scs_pkg::ST_WD;
  localparam scs_pkg::scs_state_t ST_CNT = scs_pkg::ST_CNT;
  localparam scs_pkg::scs_state_t ST_RUN = scs_pkg::ST_RUN;
  scs_pkg::scs_state_t state_q;
  logic [2:0] wd_sync_q;
  logic [2:0] src_sync_q;
  logic wd_lvl_q;
  logic src_lvl_q;
  logic [16:0] cnt_q;
  logic [16:0] tgt_q;
  logic [1:0] dly_q;
  logic rstdis_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_cs;
  logic wr_ok;
  logic sw_switch;
  logic wd_tick;
  logic src_tick;

  // fuse value zero means programmed; encodings are used as read, no inversion
  function automatic logic cfg_ok(logic [3:0] s, logic [1:0] u, logic rd);
    cfg_ok = 1'b1;
    if (s == scs_pkg::SRC_BAD) begin
      cfg_ok = 1'b0;
    end else if (!s[3] && u == scs_pkg::SUT_BAD) begin
      cfg_ok = 1'b0;
    end else if ((s == scs_pkg::SRC_RC || s == scs_pkg::SRC_WDO) && u == 2'h0 && rd) begin
      cfg_ok = 1'b0;
    end else if (s[3] && rd && ({s[0], u} == 3'h2 || {s[0], u} == 3'h5)) begin
      cfg_ok = 1'b0;
    end
  endfunction

  // wake start-up length in cycles of the selected source
  function automatic logic [16:0] wake_len(logic [3:0] s, logic [1:0] u);
    if (s[3]) begin
      case ({s[0], u})
        3'h0, 3'h1: wake_len = scs_pkg::XT_SHORT;
        3'h2, 3'h3, 3'h4: wake_len = scs_pkg::XT_MID;
        default: wake_len = XT_LONG_CYC;
      endcase
    end else if (s[3:2] == 2'b01) begin
      wake_len = (u == 2'h2) ? LF_LONG_CYC : scs_pkg::XT_MID;
    end else begin
      wake_len = scs_pkg::WAKE_SHORT;
    end
  endfunction

  // extra watchdog-timed delay class after reset
  function automatic logic [1:0] rst_dly(logic [3:0] s, logic [1:0] u, logic rd);
    if (s[3]) begin
      case ({s[0], u})
        3'h0, 3'h3, 3'h6: rst_dly = scs_pkg::DLY_SHORT;
        3'h1, 3'h4, 3'h7: rst_dly = scs_pkg::DLY_LONG;
        default: rst_dly = scs_pkg::DLY_NONE;
      endcase
    end else if (s[3:2] == 2'b01) begin
      rst_dly = (u == 2'h0) ? scs_pkg::DLY_SHORT : scs_pkg::DLY_LONG;
    end else if (u == 2'h0) begin
      rst_dly = (s == scs_pkg::SRC_EXT && rd) ? scs_pkg::DLY_SHORT : scs_pkg::DLY_NONE;
    end else begin
      rst_dly = (u == 2'h1) ? scs_pkg::DLY_SHORT : scs_pkg::DLY_LONG;
    end
  endfunction

  // low-frequency crystal has no 14-clock tail after reset
  function automatic logic [16:0] rst_ck(logic [3:0] s);
    rst_ck = (s[3:2] == 2'b01) ? 17'h00000 : scs_pkg::RST_EXTRA_CK;
  endfunction

  // three-stage synchronisers; only stages 1 and 2 feed the filtered level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_sync_q <= 3'h0;
      src_sync_q <= 3'h0;
      wd_lvl_q <= 1'b0;
      src_lvl_q <= 1'b0;
    end else if (ce) begin
      wd_sync_q <= {wd_sync_q[1:0], wd_osc_pin};
      src_sync_q <= {src_sync_q[1:0], src_osc_pin};
      if (wd_sync_q[1] == wd_sync_q[2]) begin
        wd_lvl_q <= wd_sync_q[2];
      end
      if (src_sync_q[1] == src_sync_q[2]) begin
        src_lvl_q <= src_sync_q[2];
      end
    end
  end

  assign wd_tick = wd_sync_q[1] & wd_sync_q[2] & ~wd_lvl_q;
  assign src_tick = src_sync_q[1] & src_sync_q[2] & ~src_lvl_q;

  // axi write side
  assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_cs = (awaddr_q == scs_pkg::ADDR_CLKSEL) & wstrb_q[0];
  assign wr_ok = cfg_ok(wdata_q[3:0], wdata_q[5:4], rstdis_q) && state_q == ST_RUN;
  assign sw_switch = wr_fire & wr_cs & wr_ok;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == scs_pkg::ADDR_TRIM) begin
          s_axi_bresp <= scs_pkg::RESP_OKAY;
        end else if (awaddr_q == scs_pkg::ADDR_CLKSEL) begin
          // refused selections answer with an error and leave the clock alone
          s_axi_bresp <= (wr_ok || !wstrb_q[0]) ? scs_pkg::RESP_OKAY : scs_pkg::RESP_SLVERR;
        end else begin
          s_axi_bresp <= scs_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= scs_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= scs_pkg::RESP_OKAY;
        case (s_axi_araddr)
          scs_pkg::ADDR_CLKSEL: s_axi_rdata <= {26'h0, startup_time_field, source_select_field};
          scs_pkg::ADDR_TRIM: s_axi_rdata <= {24'h0, osc_trim_register};
          scs_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, cpu_run, startup_busy, dly_q,
                                                 rstdis_q, div8_enable, xtal_range};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= scs_pkg::RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // clock select and trim registers; fuses are caught in the first cycle after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      source_select_field <= scs_pkg::DEF_SRC;
      startup_time_field <= scs_pkg::DEF_SUT;
      div8_enable <= 1'b1;
      rstdis_q <= 1'b0;
      osc_trim_register <= scs_pkg::DEF_TRIM;
    end else if (ce) begin
      if (state_q == ST_LOAD) begin
        rstdis_q <= ~reset_pin_disable_fuse;
        div8_enable <= ~divide_by_eight_fuse;
        osc_trim_register <= factory_trim;
        // unusable fuse settings fall back to the factory default
        if (cfg_ok(clock_source_fuses, startup_time_fuses, ~reset_pin_disable_fuse)) begin
          source_select_field <= clock_source_fuses;
          startup_time_field <= startup_time_fuses;
        end
      end else if (sw_switch) begin
        source_select_field <= wdata_q[scs_pkg::CS_SRC_LSB +: 4];
        startup_time_field <= wdata_q[scs_pkg::CS_SUT_LSB +: 2];
      end
      if (wr_fire && awaddr_q == scs_pkg::ADDR_TRIM && wstrb_q[0]) begin
        osc_trim_register <= wdata_q[7:0];
      end
    end
  end

  // start-up sequencer; the watchdog oscillator always times the reset part
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_LOAD;
      cnt_q <= 17'h00000;
      tgt_q <= 17'h00000;
      dly_q <= scs_pkg::DLY_NONE;
    end else if (ce) begin
      case (state_q)
        ST_LOAD: begin
          state_q <= ST_WD;
          cnt_q <= 17'h00000;
        end
        ST_WD: begin
          dly_q <= rst_dly(source_select_field, startup_time_field, rstdis_q);
          tgt_q <= (dly_q == scs_pkg::DLY_LONG) ? WD_LONG_CYC : WD_SHORT_CYC;
          if (wd_tick) begin
            cnt_q <= cnt_q + 17'h00001;
          end
          if (rst_dly(source_select_field, startup_time_field, rstdis_q) == scs_pkg::DLY_NONE
              || (cnt_q == tgt_q && tgt_q != 17'h00000)) begin
            state_q <= ST_CNT;
            cnt_q <= 17'h00000;
            tgt_q <= wake_len(source_select_field, startup_time_field)
                     + rst_ck(source_select_field);
          end
        end
        ST_CNT: begin
          if (cnt_q >= tgt_q) begin
            state_q <= ST_RUN;
          end else if (src_tick) begin
            cnt_q <= cnt_q + 17'h00001;
          end
        end
        ST_RUN: begin
          if (sw_switch) begin
            state_q <= ST_CNT;
            cnt_q <= 17'h00000;
            tgt_q <= wake_len(wdata_q[3:0], wdata_q[5:4]);
          end else if (wake_req) begin
            state_q <= ST_CNT;
            cnt_q <= 17'h00000;
            tgt_q <= wake_len(source_select_field, startup_time_field);
          end
        end
        default: state_q <= ST_LOAD;
      endcase
    end
  end

  // pin-facing decode outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xtal_range <= 2'h0;
      osc_amp_enable <= 1'b0;
      cpu_run <= 1'b0;
      startup_busy <= 1'b1;
      watchdog_on_wdosc <= 1'b1;
    end else if (ce) begin
      xtal_range <= source_select_field[2:1];
      osc_amp_enable <= source_select_field[3] | (source_select_field[3:2] == 2'b01);
      cpu_run <= (state_q == ST_RUN) && !sw_switch && !wake_req;
      startup_busy <= (state_q != ST_RUN) || sw_switch || wake_req;
      watchdog_on_wdosc <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence wake_start_s;
    ce && state_q == ST_RUN && wake_req && !sw_switch;
  endsequence
  sequence count_done_s;
    ce && state_q == ST_CNT && cnt_q >= tgt_q;
  endsequence

  bad_src_refused_a: assert property (
    (ce && wr_fire && wr_cs && wdata_q[3:0] == scs_pkg::SRC_BAD)
      |=> source_select_field != scs_pkg::SRC_BAD)
    else $error("refused source encoding was applied");
  run_after_count_a: assert property (
    (ce && state_q != ST_RUN) ##1 (ce && state_q == ST_RUN) |-> $past(cnt_q >= tgt_q))
    else $error("execution began before start-up count finished");
  wd_delay_len_a: assert property (
    (ce && state_q == ST_WD && dly_q == scs_pkg::DLY_SHORT && tgt_q != 17'h00000)
      |-> tgt_q == WD_SHORT_CYC)
    else $error("short reset delay does not use 512 watchdog cycles");
  trim_loaded_a: assert property (
    (ce && state_q == ST_LOAD) |=> osc_trim_register == $past(factory_trim))
    else $error("factory trim not loaded at reset");
  trim_write_a: assert property (
    (ce && wr_fire && awaddr_q == scs_pkg::ADDR_TRIM && wstrb_q[0] && state_q != ST_LOAD)
      |=> osc_trim_register == $past(wdata_q[7:0]))
    else $error("trim write not applied");
  wdosc_kept_a: assert property (
    $past(ce) |-> watchdog_on_wdosc)
    else $error("watchdog left its own oscillator");
  rc_wake_len_a: assert property (
    wake_start_s ##0 (source_select_field == scs_pkg::SRC_RC)
      |=> state_q == ST_CNT && tgt_q == scs_pkg::WAKE_SHORT)
    else $error("rc wake start-up is not 6 clocks");
  rstdis_code_a: assert property (
    (rstdis_q && (source_select_field == scs_pkg::SRC_RC
                  || source_select_field == scs_pkg::SRC_WDO))
      |-> startup_time_field != 2'h0)
    else $error("short start-up code used with reset pin disabled");
  xtal_range_a: assert property (
    (ce && source_select_field[3]) |=> xtal_range == $past(source_select_field[2:1]))
    else $error("crystal range does not follow select bits");
  run_follows_a: assert property (
    count_done_s |=> state_q == ST_RUN ##1 (!$past(ce) || cpu_run || $past(wake_req)
      || $past(sw_switch)))
    else $error("run not reached after count");
endmodule
`default_nettype wire
